/* shared/pmm_pkg.sv */
/*
 * pmm_pkg: constants, register map and carrier types of the program
 * memory map block with its two identification words.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz core clock.
 */
`default_nettype none
package pmm_pkg;
    // program space geometry
    localparam int PC_W = 15;                         // fetch counter width
    localparam int PM_ADDR_W = 13;                    // implemented address bits
    localparam int PM_DEPTH = 8192;                   // implemented words
    localparam int PM_WORD_W = 14;                    // program word width
    localparam logic [14:0] PM_LAST_ADDR = 15'h1FFF;
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004;
    // indirect pointer decode
    localparam int PTR_PROG_BIT = 15;                 // bit 7 of the high byte
    localparam int IND_DATA_W = 8;
    // identification word layout
    localparam int ID_FIX_HI_POS = 13;
    localparam int ID_FIX_LO_POS = 12;
    localparam int MAJOR_LSB = 6;
    localparam int MINOR_LSB = 0;
    localparam int PART_LSB = 0;
    localparam logic [1:0] REV_FIXED = 2'h2;          // bit 13 one, bit 12 zero
    localparam logic [1:0] PART_FIXED = 2'h3;         // bits 13 and 12 both one
    // register indices; byte address is four times the index
    localparam int AXI_ADDR_W = 18;
    localparam logic [15:0] IDX_CTRL = 16'h0000;
    localparam logic [15:0] IDX_PC_STATUS = 16'h0001;
    localparam logic [15:0] IDX_LOAD_ADDR = 16'h0002;
    localparam logic [15:0] IDX_LOAD_DATA = 16'h0003;
    localparam logic [15:0] IDX_REVISION = 16'h8005;
    localparam logic [15:0] IDX_PART_CODE = 16'h8006;
    localparam int CTRL_RUN_POS = 0;
    localparam logic CTRL_RUN_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing of the indirect port in clock cycles
    localparam int DATA_READ_CYCLES = 1;
    localparam int PROG_READ_CYCLES = DATA_READ_CYCLES + 1;

    typedef enum logic [1:0] {
        PMM_IND_IDLE = 2'b01,
        PMM_IND_PROG = 2'b10
    } pmm_ind_e_t;

    // fetch steering from the core
    typedef struct packed {
        logic step;
        logic intAccept;
        logic branch;
        logic [PC_W-1:0] target;
    } pmm_fetch_ctl_t;

    // indirect data port request
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] ptr;
        logic [IND_DATA_W-1:0] wdata;
    } pmm_ind_req_t;

    // registered state of the block, apart from the memory, its two read registers and the reset flops
    typedef struct packed {
        logic [PC_W-1:0] pc;
        pmm_ind_e_t indState;
        logic indAck;
        logic [IND_DATA_W-1:0] indRdata;
        logic awHeld;
        logic wHeld;
        logic [AXI_ADDR_W-1:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic runEn;
        logic [PM_ADDR_W-1:0] loadAddr;
    } pmm_state_t;
endpackage
`default_nettype wire

/* rtl/pmm_program_map.sv */
/*
 * pmm_program_map: program memory with fetch counter, reset and
 * interrupt vectors, indirect read of program memory as data, and the
 * read-only revision and part identification words over AXI4-Lite.
 * Assumes core-side inputs are on clk_sys and a data memory that
 * answers dmRdata in the same cycle as dmReq.
 */
// Our own choice: the AXI4-Lite slave port.
// Summary of operation
// - revision word read-only, bit 13 one
// - revision word bit 12 always zero
// - bits 11:6 hold major revision
// - bits 5:0 hold minor revision
// - part word read-only, bits 13:12 one
// - bits 11:0 hold fixed part code
// - 15-bit counter addresses 32K by 14
// - above 0x1FFF wrap using low 13 bits
// - reset starts at 0000h, interrupt 0004h
// - pointer bit 7 high reads program memory
// - indirect move returns low eight bits
// - indirect writes leave program memory unchanged
// - program reads take one extra cycle
`timescale 1ns/100ps
`default_nettype none
module pmm_program_map #(
    parameter logic [5:0] MAJOR_REV = 6'h01,          // arbitrary value
    parameter logic [5:0] MINOR_REV = 6'h00,          // arbitrary value
    parameter logic [11:0] PART_CODE = 12'h0A5        // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire pmm_pkg::pmm_fetch_ctl_t fetchCtl,
    output logic [pmm_pkg::PC_W-1:0] fetchAddr,
    output logic [pmm_pkg::PM_WORD_W-1:0] instrWord,
    input wire pmm_pkg::pmm_ind_req_t indReq,
    output logic indReady,
    output logic indAck,
    output logic [pmm_pkg::IND_DATA_W-1:0] indRdata,
    output logic dmReq,
    output logic dmWrite,
    output logic [15:0] dmAddr,
    output logic [pmm_pkg::IND_DATA_W-1:0] dmWdata,
    input wire logic [pmm_pkg::IND_DATA_W-1:0] dmRdata,
    input wire logic [pmm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pmm_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pmm_pkg::*;

    pmm_state_t state_reg;
    pmm_state_t state_next;
    logic [1:0] rstSync_reg;
    logic rstInt_n;
    logic [PM_WORD_W-1:0] progMem [PM_DEPTH];
    logic [PM_WORD_W-1:0] fetchWord_reg;
    logic [PM_WORD_W-1:0] indWord_reg;
    logic memWe;
    logic [PM_ADDR_W-1:0] memWaddr;
    logic [PM_WORD_W-1:0] memWdata;
    logic [PM_ADDR_W-1:0] fetchIdx;
    logic [PM_ADDR_W-1:0] indIdx;
    logic [13:0] revisionWord;
    logic [13:0] partCodeWord;
    logic indTake;
    logic indIsProg;
    logic wrFire;
    logic [15:0] wrIdx;
    logic [15:0] rdIdx;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstInt_n = rstSync_reg[1];

    // fixed identification words, no storage behind them
    assign revisionWord = {REV_FIXED, MAJOR_REV, MINOR_REV};
    assign partCodeWord = {PART_FIXED, PART_CODE};

    // address folding into the implemented space
    assign fetchIdx = state_reg.pc[PM_ADDR_W-1:0];
    assign indIdx = indReq.ptr[PM_ADDR_W-1:0];
    assign indTake = indReq.valid && (state_reg.indState == PMM_IND_IDLE) && !state_reg.indAck;
    assign indIsProg = indReq.ptr[PTR_PROG_BIT];
    assign wrFire = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
    assign wrIdx = state_reg.awAddr[AXI_ADDR_W-1:2];
    assign rdIdx = s_axi_araddr[AXI_ADDR_W-1:2];

    // program memory: only the register bus loader writes it
    assign memWe = wrFire && (wrIdx == IDX_LOAD_DATA) && (&state_reg.wStrb[1:0]);
    assign memWaddr = state_reg.loadAddr;
    assign memWdata = state_reg.wData[PM_WORD_W-1:0];

    // memory array with two synchronous read ports
    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            progMem[memWaddr] <= memWdata;
        end
        fetchWord_reg <= progMem[fetchIdx];
        indWord_reg <= progMem[indIdx];
    end

    // next-state logic of the whole block
    always_comb begin
        state_next = state_reg;
        state_next.indAck = 1'b0;
        // fetch counter
        if (!state_reg.runEn) begin
            state_next.pc = RESET_VECTOR;
        end else if (fetchCtl.step) begin
            if (fetchCtl.intAccept) begin
                state_next.pc = INT_VECTOR;
            end else if (fetchCtl.branch) begin
                state_next.pc = fetchCtl.target;
            end else begin
                state_next.pc = state_reg.pc + 15'h0001;
            end
        end
        // indirect data port
        case (state_reg.indState)
            PMM_IND_IDLE: begin
                if (indTake) begin
                    if (!indIsProg) begin
                        state_next.indAck = 1'b1;
                        state_next.indRdata = indReq.write ? 8'h00 : dmRdata;
                    end else if (indReq.write) begin
                        state_next.indAck = 1'b1;
                        state_next.indRdata = 8'h00;
                    end else begin
                        state_next.indState = PMM_IND_PROG;
                    end
                end
            end
            PMM_IND_PROG: begin
                state_next.indAck = 1'b1;
                state_next.indRdata = indWord_reg[IND_DATA_W-1:0];
                state_next.indState = PMM_IND_IDLE;
            end
            default: begin
                state_next.indState = PMM_IND_IDLE;
            end
        endcase
        // bus write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.awHeld = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.wHeld = 1'b1;
            state_next.wData = s_axi_wdata;
            state_next.wStrb = s_axi_wstrb;
        end
        if (wrFire) begin
            state_next.awHeld = 1'b0;
            state_next.wHeld = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = RESP_OKAY;
            case (wrIdx)
                IDX_CTRL: begin
                    if (state_reg.wStrb[0]) begin
                        state_next.runEn = state_reg.wData[CTRL_RUN_POS];
                    end
                end
                IDX_LOAD_ADDR: begin
                    if (&state_reg.wStrb[1:0]) begin
                        state_next.loadAddr = state_reg.wData[PM_ADDR_W-1:0];
                    end
                end
                IDX_LOAD_DATA: begin
                    if (memWe) begin
                        state_next.loadAddr = state_reg.loadAddr + 13'h0001;
                    end
                end
                IDX_PC_STATUS, IDX_REVISION, IDX_PART_CODE: begin
                    state_next.bResp = RESP_OKAY;
                end
                default: begin
                    state_next.bResp = RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end
        // bus read channel
        if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rValid = 1'b1;
            state_next.rResp = RESP_OKAY;
            state_next.rData = 32'h0000_0000;
            case (rdIdx)
                IDX_CTRL: state_next.rData[CTRL_RUN_POS] = state_reg.runEn;
                IDX_PC_STATUS: state_next.rData[PC_W-1:0] = state_reg.pc;
                IDX_LOAD_ADDR: state_next.rData[PM_ADDR_W-1:0] = state_reg.loadAddr;
                IDX_LOAD_DATA: state_next.rData = 32'h0000_0000;
                IDX_REVISION: state_next.rData[13:0] = revisionWord;
                IDX_PART_CODE: state_next.rData[13:0] = partCodeWord;
                default: state_next.rResp = RESP_SLVERR;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state_reg <= '0;
            state_reg.pc <= RESET_VECTOR;
            state_reg.indState <= PMM_IND_IDLE;
            state_reg.runEn <= CTRL_RUN_RESET;
            state_reg.bResp <= RESP_OKAY;
            state_reg.rResp <= RESP_OKAY;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign fetchAddr = state_reg.pc;
    assign instrWord = fetchWord_reg;
    assign indReady = (state_reg.indState == PMM_IND_IDLE) && !state_reg.indAck;
    assign indAck = state_reg.indAck;
    assign indRdata = state_reg.indRdata;
    assign dmReq = indTake && !indIsProg;
    assign dmWrite = indReq.write;
    assign dmAddr = indReq.ptr;
    assign dmWdata = indReq.wdata;
    assign s_axi_awready = !state_reg.awHeld && !state_reg.bValid;
    assign s_axi_wready = !state_reg.wHeld && !state_reg.bValid;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = state_reg.rResp;

    // checks on the block's own behaviour
    default clocking cbDef @(posedge clk_sys);
    endclocking
    default disable iff (!rstInt_n);

    sequence s_progReadTaken;
        indTake && indIsProg && !indReq.write;
    endsequence
    sequence s_dataTaken;
        indTake && !indIsProg;
    endsequence
    sequence s_revAsked;
        s_axi_arvalid && s_axi_arready && rdIdx == IDX_REVISION;
    endsequence

    property p_revFixed;
        s_revAsked |=> s_axi_rvalid && s_axi_rdata[ID_FIX_HI_POS] && s_axi_rresp == RESP_OKAY;
    endproperty
    a_revFixed: assert property (p_revFixed) else $error("revision fixed bits wrong");

    property p_revRead;
        (s_axi_arvalid && s_axi_arready && rdIdx == IDX_REVISION)
            |=> s_axi_rvalid && s_axi_rdata == {18'h00000, 2'h2, MAJOR_REV, MINOR_REV};
    endproperty
    a_revRead: assert property (p_revRead) else $error("revision word read wrong");

    property p_revFields;
        s_revAsked |=> s_axi_rdata[11:6] == MAJOR_REV && s_axi_rdata[5:0] == MINOR_REV
            && !s_axi_rdata[ID_FIX_LO_POS];
    endproperty
    a_revFields: assert property (p_revFields) else $error("revision fields misplaced");

    property p_partRead;
        (s_axi_arvalid && s_axi_arready && rdIdx == IDX_PART_CODE)
            |=> s_axi_rdata == {18'h00000, 2'h3, PART_CODE};
    endproperty
    a_partRead: assert property (p_partRead) else $error("part word read wrong");

    property p_pcWrap;
        (state_reg.runEn && fetchCtl.step && !fetchCtl.intAccept && !fetchCtl.branch
            && state_reg.pc == 15'h7FFF) |=> state_reg.pc == 15'h0000;
    endproperty
    a_pcWrap: assert property (p_pcWrap) else $error("counter did not wrap");

    // word fetched above the top must be the one at the masked address
    logic [PM_WORD_W-1:0] foldWord;
    assign foldWord = progMem[PM_ADDR_W'(state_reg.pc & PM_LAST_ADDR)];
    property p_fold;
        (state_reg.pc > PM_LAST_ADDR) |=> instrWord == $past(foldWord);
    endproperty
    a_fold: assert property (p_fold) else $error("fetch not folded");

    property p_intVector;
        (state_reg.runEn && fetchCtl.step && fetchCtl.intAccept) |=> fetchAddr == 15'h0004;
    endproperty
    a_intVector: assert property (p_intVector) else $error("interrupt vector wrong");

    property p_noDataForProg;
        (indTake && indIsProg) |-> !dmReq;
    endproperty
    a_noDataForProg: assert property (p_noDataForProg) else $error("program read hit data");

    property p_progLowByte;
        s_progReadTaken ##1 1'b1 |=> indAck && indRdata == $past(indWord_reg[7:0]);
    endproperty
    a_progLowByte: assert property (p_progLowByte) else $error("indirect byte wrong");

    property p_noIndWrite;
        (indTake && indIsProg && indReq.write) |-> !memWe ##1 indAck;
    endproperty
    a_noIndWrite: assert property (p_noIndWrite) else $error("indirect write reached memory");

    property p_progExtra;
        s_progReadTaken |=> !indAck ##1 indAck;
    endproperty
    a_progExtra: assert property (p_progExtra) else $error("program read timing wrong");

    property p_dataOne;
        s_dataTaken |=> indAck;
    endproperty
    a_dataOne: assert property (p_dataOne) else $error("data read timing wrong");

    property p_idStable;
        (wrFire && (wrIdx == IDX_REVISION || wrIdx == IDX_PART_CODE))
            |-> !memWe ##1 (s_axi_bvalid && s_axi_bresp == RESP_OKAY
            && $stable(state_reg.runEn) && $stable(state_reg.loadAddr));
    endproperty
    a_idStable: assert property (p_idStable) else $error("identification word changed");
endmodule
`default_nettype wire

/* dv/test_program_memory_map_id_words.sv */
/*
 * test_program_memory_map_id_words: self-checking bench for the program
 * memory map with its identification words; drives fetch, indirect port
 * and AXI4-Lite ports directly.
 * Assumes pmm_pkg is compiled first; one 100 MHz core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module test_program_memory_map_id_words;
    import pmm_pkg::*;
    localparam logic [5:0] MAJ = 6'h2D;      // arbitrary value
    localparam logic [5:0] MIN = 6'h13;      // arbitrary value
    localparam logic [11:0] PART = 12'h5C3;  // arbitrary value
    // stimulus, all set at time zero
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    pmm_fetch_ctl_t fetchCtl = '0;
    pmm_ind_req_t indReq = '0;
    logic [7:0] dmRdata = 8'h00;
    logic [AXI_ADDR_W-1:0] awAddr = '0;
    logic awValid = 1'b0;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'h0;
    logic wValid = 1'b0;
    logic bReady = 1'b0;
    logic [AXI_ADDR_W-1:0] arAddr = '0;
    logic arValid = 1'b0;
    logic rReady = 1'b0;
    // observed outputs
    logic [PC_W-1:0] fetchAddr;
    logic [PM_WORD_W-1:0] instrWord;
    logic indReady;
    logic indAck;
    logic [IND_DATA_W-1:0] indRdata;
    logic dmReq;
    logic dmWrite;
    logic [15:0] dmAddr;
    logic [7:0] dmWdata;
    logic awReady;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic arReady;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rValid;
    int nFail = 0;
    int cmpCount = 0;
    int cycleCount = 0;

    pmm_program_map #(.MAJOR_REV(MAJ), .MINOR_REV(MIN), .PART_CODE(PART)) pmm_program_map_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .fetchCtl(fetchCtl), .fetchAddr(fetchAddr),
        .instrWord(instrWord), .indReq(indReq), .indReady(indReady), .indAck(indAck),
        .indRdata(indRdata), .dmReq(dmReq), .dmWrite(dmWrite), .dmAddr(dmAddr), .dmWdata(dmWdata),
        .dmRdata(dmRdata),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycleCount++;
        if (cycleCount == 5000) begin
            nFail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one compare for every kind of result, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // reset held three cycles, first request three edges after release
    task automatic do_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        awAddr <= {idx, 2'b00};
        wData <= d;
        wStrb <= 4'hF;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        resp = bResp;
        bReady <= 1'b0;
    endtask

    // read: arvalid held until taken, rready until rvalid
    task automatic axi_read(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        arAddr <= {idx, 2'b00};
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arValid && arReady) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        d = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask

    // one indirect access, ack latency counted from the taking edge
    task automatic ind_op(input logic wr, input logic [15:0] ptr, input logic [7:0] d, input int lat,
                          input logic chkData, input logic [7:0] exp);
        int k;
        @(posedge clk_sys);
        indReq <= '{valid: 1'b1, write: wr, ptr: ptr, wdata: d};
        dmRdata <= d;
        #1;
        chk("indReady", 32'h1, {31'h0, indReady});
        chk("dmReq", {31'h0, ~ptr[15]}, {31'h0, dmReq});
        chk("dmAddr", {16'h0, ptr}, {16'h0, dmAddr});
        chk("dmWrite", {31'h0, wr}, {31'h0, dmWrite});
        chk("dmWdata", {24'h0, d}, {24'h0, dmWdata});
        @(posedge clk_sys);
        indReq <= '0;
        #1;
        k = 1;
        while (indAck !== 1'b1 && k < 8) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk("ack latency", lat, k);
        if (chkData) chk("indRdata", {24'h0, exp}, {24'h0, indRdata});
    endtask

    // one fetch step, counter then word a cycle later
    task automatic fetch_step(input logic ia, input logic br, input logic [14:0] tgt,
                              input logic [14:0] expPc, input logic [13:0] expWord);
        @(posedge clk_sys);
        fetchCtl <= '{step: 1'b1, intAccept: ia, branch: br, target: tgt};
        @(posedge clk_sys);
        fetchCtl <= '0;
        #1;
        chk("fetchAddr", {17'h0, expPc}, {17'h0, fetchAddr});
        @(posedge clk_sys);
        #1;
        chk("instrWord", {18'h0, expWord}, {18'h0, instrWord});
    endtask

    // load two consecutive words, address steps by itself
    task automatic load2(input logic [12:0] a, input logic [13:0] w0, input logic [13:0] w1);
        logic [1:0] r;
        logic [31:0] d;
        axi_write(IDX_LOAD_ADDR, {19'h0, a}, r);
        chk("load addr resp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_write(IDX_LOAD_DATA, {18'h0, w0}, r);
        chk("load data resp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_write(IDX_LOAD_DATA, {18'h0, w1}, r);
        axi_read(IDX_LOAD_ADDR, d, r);
        chk("load addr stepped", {19'h0, a + 13'h0002}, d);
    endtask

    task automatic test_ids;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 2; i++) begin
            axi_read(IDX_REVISION, d, r);
            chk("revision word", {18'h0, 2'b10, MAJ, MIN}, d);
            axi_read(IDX_PART_CODE, d, r);
            chk("part word", {18'h0, 2'b11, PART}, d);
            axi_write(IDX_REVISION, 32'h0, r);
            chk("revision write resp", {30'h0, RESP_OKAY}, {30'h0, r});
            axi_write(IDX_PART_CODE, 32'hFFFFFFFF, r);
        end
        axi_read(16'h8007, d, r);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        axi_write(16'h8007, 32'h0, r);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test identification words done");
    endtask

    task automatic test_reset_state;
        logic [31:0] d;
        logic [1:0] r;
        #1;
        chk("reset fetchAddr", {17'h0, RESET_VECTOR}, {17'h0, fetchAddr});
        axi_read(IDX_CTRL, d, r);
        chk("ctrl reset", 32'h0, d);
        $display("test reset state done");
    endtask

    task automatic test_indirect;
        ind_op(1'b0, 16'h8004, 8'h00, 2, 1'b1, 8'h5C);
        ind_op(1'b0, 16'hBFFF, 8'h00, 2, 1'b1, 8'h7E);
        ind_op(1'b0, 16'h0004, 8'hC3, 1, 1'b1, 8'hC3);
        ind_op(1'b1, 16'h8004, 8'hFF, 1, 1'b1, 8'h00);
        ind_op(1'b1, 16'h0010, 8'hA5, 1, 1'b1, 8'h00);
        ind_op(1'b0, 16'h8004, 8'h00, 2, 1'b1, 8'h5C);
        $display("test indirect port done");
    endtask

    task automatic test_fetch;
        logic [1:0] r;
        logic [31:0] d;
        fetch_step(1'b0, 1'b0, 15'h0, RESET_VECTOR, 14'h1234);
        axi_write(IDX_CTRL, 32'h1, r);
        fetch_step(1'b1, 1'b1, 15'h1FFE, INT_VECTOR, 14'h2A5C);
        fetch_step(1'b0, 1'b0, 15'h0, 15'h0005, 14'h15A3);
        axi_read(IDX_PC_STATUS, d, r);
        chk("pc status", 32'h0000_0005, d);
        fetch_step(1'b0, 1'b1, 15'h7FFE, 15'h7FFE, 14'h3C81);
        fetch_step(1'b0, 1'b0, 15'h0, 15'h7FFF, 14'h0F7E);
        fetch_step(1'b0, 1'b0, 15'h0, 15'h0000, 14'h1234);
        $display("test fetch done");
    endtask

    // main sequence, second reset in mid-run
    initial begin
        do_reset();
        test_reset_state();
        test_ids();
        load2(13'h1FFE, 14'h3C81, 14'h0F7E);
        load2(13'h0004, 14'h2A5C, 14'h15A3);
        load2(13'h0000, 14'h1234, 14'h0567);
        test_indirect();
        test_fetch();
        do_reset();
        test_reset_state();
        test_ids();
        report_and_stop();
    end
endmodule
`default_nettype wire
